// ==== dacsh_regs.svh ====
`ifndef DACSH_REGS_SVH
`define DACSH_REGS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define DACSH_ADDR_W 3
`define DACSH_DATA_W 8
`define DACSH_ADDR_HIGH 3'h0
`define DACSH_ADDR_LOW 3'h1
`define DACSH_ADDR_CTRL 3'h2
`define DACSH_ADDR_STAT 3'h3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DACSH_RST_BYTE 8'h00
`define DACSH_RST_VALUE 10'h000
`define DACSH_RST_FLAGS 8'h00

// ------------------------------------------------------------
// field layout
// ------------------------------------------------------------
`define DACSH_VALUE_W 10
`define DACSH_TRIG_N 8
`define DACSH_SEL_W 3
`define DACSH_STAT_PEND_BIT 0

`endif

// ==== dacsh_pkg.sv ====
package dacsh_pkg;

  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic auto_trigger_enable;
    logic [2:0] trigger_select;
    logic reserved;
    logic left_adjust;
    logic output_enable;
    logic converter_enable;
  } dacsh_ctrl_s;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } dacsh_bus_req_s;

endpackage

// ==== dacsh_top.sv ====
// Overview of operation
// - with left adjust off, value bits 9:8 sit in high byte bits 1:0 and bits 7:0 fill the low byte.
// - with left adjust on, value bits 9:2 fill the high byte and bits 1:0 sit in low byte bits 7:6.
// - both data bytes are software read/write and reset to zero.
// - the converter is fed from a hidden shadow copy so no half-written value reaches it.
// - without auto trigger, each high byte write loads the shadow from both data bytes.
// - with auto trigger, the shadow loads on the selected trigger event instead of the write.
// - in auto trigger mode a 10-bit update needs the low then the high byte written first.
// - in auto trigger mode with only the high byte written, every trigger event updates.
// - a low byte write alone never changes the output until the high byte is written.
// - changing left adjust reaches the output only at the next update.
// - a 3-bit select picks one of eight interrupt flags whose rising edge triggers.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "dacsh_regs.svh"
`default_nettype none

module dacsh_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire dacsh_pkg::dacsh_bus_req_s bus_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] trig_flags_i,
  output logic [9:0] converter_value_o,
  output logic converter_enable_o,
  output logic output_enable_o
);
  import dacsh_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // reassemble a right-aligned value from the two bytes
  function automatic logic [9:0] assemble(
    input logic [7:0] hi,
    input logic [7:0] lo,
    input logic la
  );
    logic [9:0] v;
    if (la) begin
      v = {hi, lo[7:6]};
    end else begin
      v = {hi[1:0], lo};
    end
    return v;
  endfunction

  function automatic logic is_write(
    input dacsh_bus_req_s req,
    input logic [2:0] a
  );
    return req.write && (req.addr == a);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] converter_value_high;
  logic [7:0] converter_value_low;
  dacsh_ctrl_s converter_control;
  logic [9:0] shadow;
  // set by a low write and cleared by a high write; while set it holds
  // every trigger off but one in the high write's cycle, so a half-written pair never reaches the output
  logic low_pending;
  logic [7:0] flags_prev;
  logic [7:0] rdata;

  logic [7:0] next_converter_value_high;
  logic [7:0] next_converter_value_low;
  dacsh_ctrl_s next_converter_control;
  logic [9:0] next_shadow;
  logic next_low_pending;
  logic [7:0] next_rdata;

  logic high_wr;
  logic low_wr;
  logic ctrl_wr;
  logic trig_hit;
  logic load_shadow;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] edges;
    edges = '0;
    high_wr = is_write(bus_i, `DACSH_ADDR_HIGH);
    low_wr = is_write(bus_i, `DACSH_ADDR_LOW);
    ctrl_wr = is_write(bus_i, `DACSH_ADDR_CTRL);

    next_converter_value_high = converter_value_high;
    next_converter_value_low = converter_value_low;
    next_converter_control = converter_control;
    if (high_wr) begin
      next_converter_value_high = bus_i.wdata;
    end
    if (low_wr) begin
      next_converter_value_low = bus_i.wdata;
    end
    if (ctrl_wr) begin
      next_converter_control = dacsh_ctrl_s'(bus_i.wdata);
      next_converter_control.reserved = 1'b0;
    end

    // flags come from logic on this clock, so no synchroniser
    // all eight flags are kept, so moving the select onto a flag that is
    // already high does not count as an edge: the select may change at any time
    edges = trig_flags_i & ~flags_prev;
    trig_hit = edges[converter_control.trigger_select];

    // a low write without its high write blocks trigger loads
    next_low_pending = low_pending;
    if (high_wr) begin
      next_low_pending = 1'b0;
    end else if (low_wr) begin
      next_low_pending = 1'b1;
    end

    if (converter_control.auto_trigger_enable) begin
      load_shadow = trig_hit && !next_low_pending;
    end else begin
      load_shadow = high_wr;
    end

    // sample the bytes as they stand after this cycle's write,
    // so a trigger coinciding with a high write takes the new pair
    next_shadow = shadow;
    if (load_shadow) begin
      next_shadow = assemble(next_converter_value_high,
        next_converter_value_low, converter_control.left_adjust);
    end

    next_rdata = '0;
    if (bus_i.read) begin
      unique case (bus_i.addr)
        `DACSH_ADDR_HIGH: next_rdata = converter_value_high;
        `DACSH_ADDR_LOW: next_rdata = converter_value_low;
        `DACSH_ADDR_CTRL: next_rdata = converter_control;
        `DACSH_ADDR_STAT: begin
          next_rdata[`DACSH_STAT_PEND_BIT] = low_pending;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      converter_value_high <= `DACSH_RST_BYTE;
      converter_value_low <= `DACSH_RST_BYTE;
      converter_control <= `DACSH_RST_BYTE;
      shadow <= `DACSH_RST_VALUE;
      low_pending <= 1'b0;
      flags_prev <= `DACSH_RST_FLAGS;
      rdata <= `DACSH_RST_BYTE;
    end else begin
      converter_value_high <= next_converter_value_high;
      converter_value_low <= next_converter_value_low;
      converter_control <= next_converter_control;
      shadow <= next_shadow;
      low_pending <= next_low_pending;
      flags_prev <= trig_flags_i;
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;
  assign converter_value_o = shadow;
  assign converter_enable_o = converter_control.converter_enable;
  assign output_enable_o = converter_control.output_enable;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence seq_write_high;
    bus_i.write && bus_i.addr == `DACSH_ADDR_HIGH;
  endsequence

  sequence seq_write_low;
    bus_i.write && bus_i.addr == `DACSH_ADDR_LOW;
  endsequence

  sequence seq_read_high;
    bus_i.read && bus_i.addr == `DACSH_ADDR_HIGH;
  endsequence

  // seq_trig_edge and AST_TRIG_CAUSE use the raw flags, not the internal edge vector
  sequence seq_trig_edge;
    trig_flags_i[converter_control.trigger_select]
      && !flags_prev[converter_control.trigger_select];
  endsequence

  AST_MANUAL_LOAD: assert property (
    seq_write_high ##0 !converter_control.auto_trigger_enable
    |=> shadow == assemble(converter_value_high, converter_value_low,
      converter_control.left_adjust))
    else $error("high write did not load shadow");

  AST_LOW_ALONE: assert property (
    seq_write_low ##0 !trig_hit |=> $stable(shadow))
    else $error("low write changed the output");

  AST_AUTO_IGNORES_WRITE: assert property (
    seq_write_high ##0 converter_control.auto_trigger_enable
    ##0 !trig_hit |=> $stable(shadow))
    else $error("auto mode loaded on a write");

  AST_TRIG_CAUSE: assert property (
    converter_control.auto_trigger_enable && $changed(next_shadow)
    |-> trig_flags_i[converter_control.trigger_select]
      && !flags_prev[converter_control.trigger_select])
    else $error("auto load without a rising trigger edge");

  AST_PENDING_BLOCKS: assert property (
    seq_write_low ##1 !bus_i.write
    |-> !load_shadow ##1 (bus_i.write || !load_shadow))
    else $error("trigger loaded a half-written value");

  AST_LOW_THEN_HIGH: assert property (
    seq_write_low ##1 seq_write_high
    ##0 converter_control.auto_trigger_enable ##1 trig_hit
    ##0 converter_control.auto_trigger_enable && !bus_i.write
    |-> load_shadow)
    else $error("trigger after low and high did not load");

  AST_EIGHT_BIT: assert property (
    converter_control.auto_trigger_enable && trig_hit
    && !low_pending && !low_wr |-> load_shadow)
    else $error("trigger missed in 8-bit use");

  AST_HIDDEN: assert property (
    !load_shadow |=> $stable(shadow))
    else $error("shadow moved without a load");

  AST_READBACK: assert property (
    seq_write_high ##1 seq_read_high
    |=> rdata_o == $past(bus_i.wdata, 2))
    else $error("high byte readback wrong");

  // strobes may also come with an idle cycle between them
  AST_READBACK_GAP: assert property (
    seq_write_high ##1 !bus_i.write ##1 seq_read_high
    |=> rdata_o == $past(bus_i.wdata, 3))
    else $error("high byte readback after idle wrong");

  AST_RDATA_IDLE: assert property (
    !bus_i.read |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");

  AST_LA_DEFER: assert property (
    bus_i.write && bus_i.addr == `DACSH_ADDR_CTRL && !load_shadow
    |=> $stable(shadow))
    else $error("left adjust change moved the output");

  AST_RIGHT_ALIGN: assert property (
    load_shadow && !converter_control.left_adjust
    |=> shadow[7:0] == converter_value_low)
    else $error("right-adjusted load misplaced bits");

  AST_LEFT_ALIGN: assert property (
    load_shadow && converter_control.left_adjust
    |=> shadow[9:2] == converter_value_high)
    else $error("left-adjusted load misplaced bits");

  AST_RIGHT_HIGH: assert property (
    load_shadow && !converter_control.left_adjust
    |=> shadow[9:8] == converter_value_high[1:0])
    else $error("right-adjusted load misplaced high bits");

  AST_LEFT_LOW: assert property (
    load_shadow && converter_control.left_adjust
    |=> shadow[1:0] == converter_value_low[7:6])
    else $error("left-adjusted load misplaced low bits");

  AST_MANUAL_NO_TRIG: assert property (
    !converter_control.auto_trigger_enable && trig_hit && !high_wr
    |=> $stable(shadow))
    else $error("trigger loaded the shadow in manual mode");

  AST_PENDING_SET: assert property (
    seq_write_low |=> low_pending)
    else $error("low write did not mark the pair incomplete");

  AST_PENDING_CLEAR: assert property (
    seq_write_high |=> !low_pending)
    else $error("high write did not complete the pair");

  AST_TRIG_LOADS: assert property (
    converter_control.auto_trigger_enable && !bus_i.write && !low_pending
    ##0 seq_trig_edge |-> load_shadow)
    else $error("selected rising edge did not load");

endmodule

`default_nettype wire

// ==== dacsh_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dacsh_regs.svh"

module dacsh_top_tb;
  import dacsh_pkg::*;

  // ----------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  dacsh_bus_req_s bus = '0;
  logic [7:0] flags = 8'h00;
  logic [7:0] rdata;
  logic [9:0] value;
  logic conv_en;
  logic out_en;
  int err_count = 0;
  int checked = 0;
  logic [9:0] prev;

  dacsh_top DUT (
    .clk_i(clk),
    .reset_n_i(reset_n),
    .bus_i(bus),
    .rdata_o(rdata),
    .trig_flags_i(flags),
    .converter_value_o(value),
    .converter_enable_o(conv_en),
    .output_enable_o(out_en)
  );

  always #10 clk = ~clk;

  // ----------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------
  task automatic check(input string name, input logic [9:0] seen,
                       input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // the strobe drops at the end edge, so the next call waits one edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.write <= 1'b1;
    @(posedge clk);
    bus.write <= 1'b0;
  endtask

  // low then high on consecutive edges; t >= 0 raises that flag in
  // the cycle right after the high byte is taken
  task automatic wr_pair(input logic [7:0] lo, input logic [7:0] hi,
                         input int t);
    @(posedge clk);
    bus.addr <= `DACSH_ADDR_LOW;
    bus.wdata <= lo;
    bus.write <= 1'b1;
    @(posedge clk);
    bus.addr <= `DACSH_ADDR_HIGH;
    bus.wdata <= hi;
    @(posedge clk);
    bus.write <= 1'b0;
    if (t >= 0) begin
      flags[t] <= 1'b1;
    end
    @(posedge clk);
    flags <= 8'h00;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp,
                        input string name);
    @(posedge clk);
    bus.addr <= a;
    bus.read <= 1'b1;
    @(posedge clk);
    bus.read <= 1'b0;
    @(negedge clk);
    check(name, {2'h0, rdata}, {2'h0, exp});
  endtask

  // gives the load and the output register time to settle
  task automatic val_chk(input logic [9:0] exp);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("converter_value", value, exp);
  endtask

  task automatic trig(input int n);
    @(posedge clk);
    flags[n] <= 1'b1;
    @(posedge clk);
    flags <= 8'h00;
  endtask

  task automatic finish_test;
    $display("checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(`DACSH_ADDR_HIGH, 8'h00, "high");
    rd_chk(`DACSH_ADDR_LOW, 8'h00, "low");
    val_chk(10'h000);
    wr(`DACSH_ADDR_LOW, 8'hFF);
    wr(`DACSH_ADDR_HIGH, 8'hFF);
    rd_chk(`DACSH_ADDR_HIGH, 8'hFF, "high");
    rd_chk(`DACSH_ADDR_LOW, 8'hFF, "low");
    val_chk(10'h3FF);
    wr(`DACSH_ADDR_CTRL, 8'h0F);
    rd_chk(`DACSH_ADDR_CTRL, 8'h07, "control");
    check("enables", {8'h00, conv_en, out_en}, 10'h003);
    rd_chk(3'h5, 8'h00, "unmapped");
    // manual mode, right adjusted
    wr(`DACSH_ADDR_CTRL, 8'h03);
    wr(`DACSH_ADDR_LOW, 8'h5A);
    val_chk(10'h3FF);
    wr(`DACSH_ADDR_HIGH, 8'h03);
    val_chk(10'h35A);
    // alignment change alone must not disturb the output
    wr(`DACSH_ADDR_CTRL, 8'h07);
    val_chk(10'h35A);
    trig(0);
    val_chk(10'h35A);
    wr(`DACSH_ADDR_LOW, 8'hC0);
    wr(`DACSH_ADDR_HIGH, 8'hA5);
    val_chk(10'h297);
    prev = 10'h297;
    // auto mode, every trigger source in turn
    for (int s = 0; s < 8; s++) begin
      wr(`DACSH_ADDR_CTRL, {1'b1, s[2:0], 4'h3});
      wr(`DACSH_ADDR_LOW, s[7:0]);
      wr(`DACSH_ADDR_HIGH, 8'h02);
      val_chk(prev);
      trig((s + 1) % 8);
      val_chk(prev);
      trig(s);
      prev = {2'b10, s[7:0]};
      val_chk(prev);
    end
    // a pending low byte blocks the trigger
    wr(`DACSH_ADDR_LOW, 8'hEE);
    trig(7);
    val_chk(prev);
    rd_chk(`DACSH_ADDR_STAT, 8'h01, "status");
    wr(`DACSH_ADDR_HIGH, 8'h01);
    trig(7);
    val_chk(10'h1EE);
    // 8-bit use, left adjusted, high byte only
    wr(`DACSH_ADDR_CTRL, 8'hF7);
    wr(`DACSH_ADDR_HIGH, 8'h40);
    trig(7);
    val_chk(10'h103);
    wr(`DACSH_ADDR_HIGH, 8'h80);
    trig(7);
    val_chk(10'h203);
    // back-to-back pair with the trigger on the very next edge
    wr_pair(8'h33, 8'hC4, 7);
    val_chk(10'h310);
    finish_test();
  end

  // ----------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------
  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
